// ---- rtl/bdp_pkg.sv ----
/*
  bdp_pkg: constants and carrier types for the breaker display panel menu sequencer.
  Assumes a 100 MHz clock; all timing is counted as enable pulses from a millisecond divider.
*/
package bdp_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ           = 100_000_000;
  localparam int TICK_MS_NS       = 1_000_000;
  localparam int TICK_CYCLES      = TICK_MS_NS / (1_000_000_000 / CLK_HZ);
  localparam int REVERT_MS        = 4000;
  localparam int SCROLL_MS        = 4000;
  localparam int FLASH_MS         = 1000;
  localparam int PROG_TIMEOUT_MS  = 300_000;
  localparam int VERDICT_MS       = 2000;
  localparam int FLASH_COUNT      = 6;
  localparam int MS_W             = 19;

  // ------------------------------------------------------------
  // sizes and limits
  // ------------------------------------------------------------
  localparam logic [31:0] KILO_LIMIT = 32'h0000270F;  // 9999
  localparam logic [3:0]  DIGIT_MAX  = 4'h9;
  localparam int          PW_DIGITS  = 4;
  localparam logic [4:0]  METER_LAST = 5'h11;
  localparam logic [4:0]  PROG_LAST  = 5'h0F;
  localparam logic [4:0]  IDX_ENERGY = 5'h0E;
  localparam logic [4:0]  IDX_REACT  = 5'h0F;
  localparam logic [4:0]  IDX_PF     = 5'h0A;
  localparam logic [4:0]  IDX_ALOG   = 5'h10;
  localparam logic [4:0]  IDX_TLOG   = 5'h11;
  localparam logic [4:0]  IDX_PWD    = 5'h01;

  // ------------------------------------------------------------
  // measured value selectors
  // ------------------------------------------------------------
  localparam logic [3:0] V_IA   = 4'h0;
  localparam logic [3:0] V_IG   = 4'h3;
  localparam logic [3:0] V_IN   = 4'h4;
  localparam logic [3:0] V_VAB  = 4'h5;
  localparam logic [3:0] V_VLN  = 4'h8;
  localparam logic [3:0] V_KW   = 4'h9;
  localparam logic [3:0] V_KWD  = 4'hA;
  localparam logic [3:0] V_KVA  = 4'hB;
  localparam logic [3:0] V_KQ   = 4'hC;
  localparam logic [3:0] V_PF   = 4'hD;
  localparam logic [3:0] V_HZ   = 4'hE;
  localparam logic [3:0] V_NONE = 4'hF;

  typedef enum logic [2:0] {
    BDP_G_CURR, BDP_G_VOLT, BDP_G_KW, BDP_G_KWD, BDP_G_KVA, BDP_G_KQ, BDP_G_PF, BDP_G_HZ
  } bdp_group_t;

  typedef enum logic [3:0] {
    BDP_MSG_NONE, BDP_MSG_DATA, BDP_MSG_PROG, BDP_MSG_NOLOG, BDP_MSG_ALOG, BDP_MSG_TLOG,
    BDP_MSG_CAUSE, BDP_MSG_CORRECT, BDP_MSG_INCORRECT, BDP_MSG_PWD, BDP_MSG_PWENTRY
  } bdp_msg_t;

  typedef enum logic [1:0] {BDP_SRC_LIVE, BDP_SRC_MAX, BDP_SRC_MIN} bdp_src_t;

  // keys as raw levels at the port; bdp_menu edge-detects them into one-cycle press pulses
  typedef struct packed {
    logic up;
    logic down;
    logic read;
    logic enter;
    logic maxk;
    logic mink;
  } bdp_keys_t;

  // log record from the trip unit
  typedef struct packed {
    logic       valid;
    logic [4:0] cause;
    bdp_group_t group;
  } bdp_log_t;

  // what the display should show
  typedef struct packed {
    bdp_msg_t   msg;
    logic [4:0] window;
    logic [4:0] cause;
    logic [3:0] value_sel;
    bdp_src_t   source;
    logic       mega;
    logic       pf_lead_flag;
    logic       blank;
    logic [15:0] pw_digits;
    logic [3:0] pw_cursor;
    logic       edit_ok;
  } bdp_disp_t;

endpackage

// ---- rtl/bdp_menu.sv ----
/*
  bdp_menu: menu and announcement sequencer of the breaker display panel.
  Assumes keys arrive as raw levels from pins; trip unit data is on clk but breaker/relay pins are synchronised here.
*/
`timescale 1ns/10ps
// What this block does
// - energy readouts switch to mega above 9999
// - max/min keys show stored extreme values
// - extreme view reverts to live after 4s
// - up/down from extreme goes to next live
// - max power factor shows lead or lag
// - alarm log read steps cause then values
// - up/down on log window moves window
// - no alarm record shows no-log message
// - alarm cause maps message and value set
// - alarm relay flashes title then shows cause
// - alarm announcement repeats until key press
// - trip log browsed like alarm log
// - trip cause maps message and value set
// - breaker trip flashes title, repeats until close/key
// - close restarts scrolling, key gives manual
// - trip announcement outranks alarm announcement
// - edits need password, viewing does not
// - program mode times out to data after 5min
// - password window: skip or start entry
// - digits entered right to left, cycling 0-9
// - final digit shows correct/incorrect verdict
// - verdict returns to password window
// - read+enter toggles modes from start
// - data mode auto-scrolls every 4s idle
module bdp_menu
  import bdp_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // operator keypad, raw levels
  input  wire bdp_keys_t   keys_raw,
  // trip unit
  input  wire logic        alarm_relay_raw,
  input  wire logic        breaker_closed_raw,
  input  wire bdp_log_t    alarm_log,
  input  wire bdp_log_t    trip_log,
  input  wire logic [31:0] energy_kwh,
  input  wire logic [31:0] energy_kqh,
  input  wire logic        pf_max_leading,
  input  wire logic [1:0]  options_gn,
  input  wire logic [15:0] password_stored,
  // display
  output bdp_disp_t        disp
);

  // ------------------------------------------------------------
  // reset release and synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n_i;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n_i = rst_sync_reg[1];

  bdp_keys_t keys_s1_reg, keys_s2_reg, keys_old_reg, kp;
  logic [1:0] alm_sync_reg, brk_sync_reg;
  logic alm_old_reg, brk_old_reg;
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      keys_s1_reg  <= '0;
      keys_s2_reg  <= '0;
      keys_old_reg <= '0;
      alm_sync_reg <= 2'h0;
      brk_sync_reg <= 2'h3;
      alm_old_reg  <= 1'b0;
      brk_old_reg  <= 1'b1;
    end else begin
      keys_s1_reg  <= keys_raw;
      keys_s2_reg  <= keys_s1_reg;
      keys_old_reg <= keys_s2_reg;
      alm_sync_reg <= {alm_sync_reg[0], alarm_relay_raw};
      brk_sync_reg <= {brk_sync_reg[0], breaker_closed_raw};
      alm_old_reg  <= alm_sync_reg[1];
      brk_old_reg  <= brk_sync_reg[1];
    end
  end
  assign kp = keys_s2_reg & ~keys_old_reg;
  wire any_key  = |kp;
  wire toggle   = kp.read & kp.enter;
  wire alm_rise = alm_sync_reg[1] & ~alm_old_reg;
  wire brk_trip = ~brk_sync_reg[1] & brk_old_reg;
  wire brk_close = brk_sync_reg[1] & ~brk_old_reg;

  // ------------------------------------------------------------
  // millisecond enable and idle timer
  // ------------------------------------------------------------
  logic [16:0]     div_reg;
  logic            ms_tick;
  logic [MS_W-1:0] idle_ms_reg;
  logic [MS_W-1:0] step_ms_reg;
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) div_reg <= '0;
    else if (div_reg == 17'(TICK_DIV - 1)) div_reg <= '0;
    else div_reg <= div_reg + 17'h1;
  end
  assign ms_tick = (div_reg == 17'(TICK_DIV - 1));

  typedef enum logic [3:0] {
    S_LIVE, S_EXTREME, S_LOGWIN, S_LOGCAUSE, S_LOGVAL, S_FLASH, S_ANN_CAUSE, S_ANN_VAL,
    S_PROG, S_PWENTRY, S_VERDICT
  } bdp_state_t;
  bdp_state_t state_reg;

  // any key restarts both inactivity timers
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) idle_ms_reg <= '0;
    else if (any_key) idle_ms_reg <= '0;
    else if (ms_tick && idle_ms_reg != {MS_W{1'b1}}) idle_ms_reg <= idle_ms_reg + 1'b1;
  end
  wire idle_4s   = ms_tick && idle_ms_reg == MS_W'(REVERT_MS - 1);
  wire idle_prog = ms_tick && idle_ms_reg == MS_W'(PROG_TIMEOUT_MS - 1);

  // ------------------------------------------------------------
  // cause decode: first value and next value of each group
  // ------------------------------------------------------------
  function automatic logic [3:0] grp_first(input bdp_group_t g);
    case (g)
      BDP_G_CURR: grp_first = V_IA;
      BDP_G_VOLT: grp_first = V_VAB;
      BDP_G_KW:   grp_first = V_KW;
      BDP_G_KWD:  grp_first = V_KWD;
      BDP_G_KVA:  grp_first = V_KVA;
      BDP_G_KQ:   grp_first = V_KQ;
      BDP_G_PF:   grp_first = V_PF;
      default:    grp_first = V_HZ;
    endcase
  endfunction

  // next value after v in group g, V_NONE when done; optional currents skipped
  function automatic logic [3:0] grp_next(input bdp_group_t g, input logic [3:0] v,
                                          input logic [1:0] opt, input logic trip);
    logic [3:0] n;
    n = v + 4'h1;
    case (g)
      BDP_G_CURR: begin
        if (n == V_IG && !opt[0]) n = V_IN;
        if (n == V_IN && !opt[1]) n = V_NONE;
        if (n > V_IN) n = V_NONE;
      end
      BDP_G_VOLT: n = (v == V_VLN) ? V_NONE : n;
      BDP_G_KW:   n = trip ? ((v == V_KW) ? V_KVA : (v == V_KVA) ? V_KQ : V_NONE) : V_NONE;
      BDP_G_HZ:   n = trip ? ((v == V_HZ) ? V_VAB : (v == V_VLN) ? V_NONE : n) : V_NONE;
      default:    n = V_NONE;
    endcase
    grp_next = n;
  endfunction

  // ------------------------------------------------------------
  // menu state
  // ------------------------------------------------------------
  logic       prog_reg, edit_ok_reg, auto_reg, ann_trip_reg, alm_pend_reg, trip_pend_reg;
  logic [4:0] win_reg;
  logic [3:0] val_reg;
  bdp_src_t   src_reg;
  logic [2:0] flash_cnt_reg;
  logic [15:0] pw_reg;
  logic [1:0] cur_reg;
  logic       verdict_ok_reg;
  bdp_log_t   cur_log;
  wire        on_trip = (win_reg == IDX_TLOG);
  assign cur_log = (state_reg inside {S_FLASH, S_ANN_CAUSE, S_ANN_VAL})
                   ? (ann_trip_reg ? trip_log : alarm_log) : (on_trip ? trip_log : alarm_log);
  wire log_trip = (state_reg inside {S_FLASH, S_ANN_CAUSE, S_ANN_VAL}) ? ann_trip_reg : on_trip;
  wire [3:0] val_nx = grp_next(cur_log.group, val_reg, options_gn, log_trip);
  wire [3:0] pw_dig = pw_reg[cur_reg*4 +: 4];

  // pending events: set wins over clear
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alm_pend_reg  <= 1'b0;
      trip_pend_reg <= 1'b0;
    end else begin
      alm_pend_reg  <= alm_rise | (alm_pend_reg & ~(state_reg == S_FLASH && !ann_trip_reg));
      trip_pend_reg <= brk_trip | (trip_pend_reg & ~(state_reg == S_FLASH && ann_trip_reg));
    end
  end

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_LIVE; prog_reg <= 1'b0; edit_ok_reg <= 1'b0; auto_reg <= 1'b1;
      win_reg <= '0; val_reg <= V_NONE; src_reg <= BDP_SRC_LIVE; ann_trip_reg <= 1'b0;
      flash_cnt_reg <= '0; step_ms_reg <= '0; pw_reg <= '0; cur_reg <= '0; verdict_ok_reg <= 1'b0;
    end else begin
      if (ms_tick) step_ms_reg <= step_ms_reg + 1'b1;
      if (toggle) begin
        prog_reg <= ~prog_reg; win_reg <= '0; src_reg <= BDP_SRC_LIVE; step_ms_reg <= '0;
        edit_ok_reg <= 1'b0;
        auto_reg <= prog_reg;
        state_reg <= prog_reg ? S_LIVE : S_PROG;
      end else if (!prog_reg && (trip_pend_reg || alm_pend_reg) &&
                   !(state_reg inside {S_FLASH, S_ANN_CAUSE, S_ANN_VAL} && ann_trip_reg)) begin
        ann_trip_reg <= trip_pend_reg;
        state_reg <= S_FLASH; flash_cnt_reg <= '0; step_ms_reg <= '0;
      end else begin
        case (state_reg)
          S_LIVE: begin
            if (kp.maxk || kp.mink) begin
              src_reg <= kp.maxk ? BDP_SRC_MAX : BDP_SRC_MIN; state_reg <= S_EXTREME;
            end else if (kp.up || kp.down) begin
              auto_reg <= 1'b0;
              win_reg <= kp.up ? (win_reg == 5'h0 ? METER_LAST : win_reg - 5'h1)
                               : (win_reg == METER_LAST ? 5'h0 : win_reg + 5'h1);
              if ((kp.up ? (win_reg == 5'h0 ? METER_LAST : win_reg - 5'h1) : win_reg + 5'h1)
                  inside {IDX_ALOG, IDX_TLOG}) state_reg <= S_LOGWIN;
            end else if (any_key) auto_reg <= 1'b0;
            // only re-arm when stopped, else the first scroll step after power-up is lost
            else if (idle_4s && !auto_reg) begin auto_reg <= 1'b1; step_ms_reg <= '0; end
            else if (auto_reg && ms_tick && step_ms_reg == MS_W'(SCROLL_MS - 1)) begin
              step_ms_reg <= '0;
              win_reg <= (win_reg >= IDX_ALOG - 5'h1) ? 5'h0 : win_reg + 5'h1;
            end
          end
          S_EXTREME: begin
            if (kp.maxk || kp.mink) src_reg <= kp.maxk ? BDP_SRC_MAX : BDP_SRC_MIN;
            else if (kp.up || kp.down) begin
              src_reg <= BDP_SRC_LIVE; state_reg <= S_LIVE;
              win_reg <= kp.up ? (win_reg == 5'h0 ? IDX_ALOG - 5'h1 : win_reg - 5'h1)
                               : (win_reg == IDX_ALOG - 5'h1 ? 5'h0 : win_reg + 5'h1);
            end else if (idle_4s) begin src_reg <= BDP_SRC_LIVE; state_reg <= S_LIVE; end
          end
          S_LOGWIN: begin
            if (kp.read) state_reg <= S_LOGCAUSE;
            else if (kp.up || kp.down) begin
              win_reg <= kp.up ? win_reg - 5'h1 : (win_reg == METER_LAST ? 5'h0 : win_reg + 5'h1);
              if (!((kp.up ? win_reg - 5'h1 : win_reg + 5'h1) inside {IDX_ALOG, IDX_TLOG})) state_reg <= S_LIVE;
            end
          end
          S_LOGCAUSE: if (kp.read || kp.down) begin
            if (cur_log.valid) begin val_reg <= grp_first(cur_log.group); state_reg <= S_LOGVAL; end
            else state_reg <= S_LOGWIN;
          end
          S_LOGVAL: if (kp.read || kp.down) begin
            val_reg <= val_nx;
            if (val_nx == V_NONE) state_reg <= S_LOGWIN;
          end
          S_FLASH: begin
            if (any_key) begin state_reg <= S_LIVE; auto_reg <= 1'b0; end
            else if (ann_trip_reg && brk_close) begin state_reg <= S_LIVE; auto_reg <= 1'b1; end
            else if (ms_tick && step_ms_reg == MS_W'(FLASH_MS - 1)) begin
              step_ms_reg <= '0;
              flash_cnt_reg <= flash_cnt_reg + 3'h1;
              if (flash_cnt_reg == 3'(FLASH_COUNT - 1)) state_reg <= S_ANN_CAUSE;
            end
          end
          S_ANN_CAUSE, S_ANN_VAL: begin
            if (any_key) begin state_reg <= S_LIVE; auto_reg <= 1'b0; end
            else if (ann_trip_reg && brk_close) begin state_reg <= S_LIVE; auto_reg <= 1'b1; end
            else if (ms_tick && step_ms_reg == MS_W'(SCROLL_MS - 1)) begin
              step_ms_reg <= '0;
              if (state_reg == S_ANN_CAUSE && cur_log.valid) begin
                val_reg <= grp_first(cur_log.group); state_reg <= S_ANN_VAL;
              end else if (state_reg == S_ANN_VAL && val_nx != V_NONE) val_reg <= val_nx;
              else begin state_reg <= S_FLASH; flash_cnt_reg <= '0; end
            end
          end
          S_PROG: begin
            if (idle_prog) begin
              prog_reg <= 1'b0; auto_reg <= 1'b1; win_reg <= '0; state_reg <= S_LIVE; step_ms_reg <= '0;
            end else if (kp.up || kp.down)
              win_reg <= kp.up ? (win_reg == 5'h0 ? PROG_LAST : win_reg - 5'h1)
                               : (win_reg == PROG_LAST ? 5'h0 : win_reg + 5'h1);
            else if (win_reg == IDX_PWD && (kp.enter || kp.read)) begin
              pw_reg <= '0; cur_reg <= '0; state_reg <= S_PWENTRY;
            end
          end
          S_PWENTRY: begin
            if (idle_prog) begin prog_reg <= 1'b0; auto_reg <= 1'b1; win_reg <= '0; state_reg <= S_LIVE; end
            else if (kp.up) pw_reg[cur_reg*4 +: 4] <= (pw_dig == DIGIT_MAX) ? 4'h0 : pw_dig + 4'h1;
            else if (kp.down) pw_reg[cur_reg*4 +: 4] <= (pw_dig == 4'h0) ? DIGIT_MAX : pw_dig - 4'h1;
            else if (kp.enter) begin
              cur_reg <= cur_reg + 2'h1;
              if (cur_reg == 2'(PW_DIGITS - 1)) begin
                verdict_ok_reg <= (pw_reg == password_stored);
                edit_ok_reg <= (pw_reg == password_stored);
                state_reg <= S_VERDICT; step_ms_reg <= '0;
              end
            end
          end
          S_VERDICT: if (ms_tick && step_ms_reg == MS_W'(VERDICT_MS - 1)) state_reg <= S_PROG;
          default: state_reg <= S_LIVE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // display output; flashing digit and title blank while bit 9 of the millisecond step count is set
  // ------------------------------------------------------------
  wire [31:0] sel_energy = (win_reg == IDX_ENERGY) ? energy_kwh : energy_kqh;
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) disp <= '0;
    else begin
      disp.window       <= win_reg;
      disp.source       <= src_reg;
      disp.cause        <= cur_log.cause;
      disp.value_sel    <= (state_reg inside {S_LOGVAL, S_ANN_VAL}) ? val_reg : V_NONE;
      disp.mega         <= (win_reg inside {IDX_ENERGY, IDX_REACT}) && sel_energy > KILO_LIMIT;
      disp.pf_lead_flag <= state_reg == S_EXTREME && src_reg == BDP_SRC_MAX && win_reg == IDX_PF
                           && pf_max_leading;
      disp.blank        <= (state_reg inside {S_FLASH, S_PWENTRY}) && step_ms_reg[9];
      disp.pw_digits    <= pw_reg;
      disp.pw_cursor    <= (state_reg == S_PWENTRY) ? 4'(4'h1 << cur_reg) : 4'h0;
      disp.edit_ok      <= edit_ok_reg;
      case (state_reg)
        S_LOGWIN, S_FLASH: disp.msg <= log_trip ? BDP_MSG_TLOG : BDP_MSG_ALOG;
        S_LOGCAUSE, S_ANN_CAUSE: disp.msg <= cur_log.valid ? BDP_MSG_CAUSE : BDP_MSG_NOLOG;
        S_PROG:    disp.msg <= (win_reg == IDX_PWD) ? BDP_MSG_PWD : BDP_MSG_PROG;
        S_PWENTRY: disp.msg <= BDP_MSG_PWENTRY;
        S_VERDICT: disp.msg <= verdict_ok_reg ? BDP_MSG_CORRECT : BDP_MSG_INCORRECT;
        default:   disp.msg <= BDP_MSG_DATA;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n_i);
  a_trip_over_alarm:  assert property (brk_trip && alm_rise && !toggle && !prog_reg ##1 !toggle
                        |=> ann_trip_reg)
    else $error("trip did not outrank alarm");
  a_key_ends_ann:     assert property (state_reg inside {S_FLASH, S_ANN_CAUSE, S_ANN_VAL} && any_key
                        && !toggle && !alm_pend_reg && !trip_pend_reg |=> state_reg == S_LIVE && !auto_reg)
    else $error("key did not end announcement");
  a_extreme_steps:    assert property (state_reg == S_EXTREME && kp.down && !kp.maxk && !kp.mink && !toggle
                        && !trip_pend_reg && !alm_pend_reg |=> state_reg == S_LIVE && win_reg == $past(win_reg) + 5'h1
                        || $past(win_reg) == IDX_ALOG - 5'h1)
    else $error("extreme view did not step");
  a_pw_digit_wrap:    assert property (state_reg == S_PWENTRY && kp.up && !toggle && !idle_prog && pw_dig == DIGIT_MAX
                        && !trip_pend_reg |=> pw_reg[$past(cur_reg)*4 +: 4] == 4'h0)
    else $error("digit did not wrap");
  a_verdict_return:   assert property (state_reg == S_VERDICT && !toggle ##1 state_reg != S_VERDICT
                        |-> state_reg == S_PROG)
    else $error("verdict left wrongly");
  a_edit_needs_pw:    assert property ($rose(edit_ok_reg) |-> state_reg == S_VERDICT && verdict_ok_reg)
    else $error("edit without password");
  a_mega_switch:      assert property (win_reg == IDX_ENERGY && energy_kwh > KILO_LIMIT ##1 win_reg == IDX_ENERGY
                        && $stable(energy_kwh) |-> disp.mega)
    else $error("mega not shown");
  a_toggle_start:     assert property (toggle |=> win_reg == 5'h0 && prog_reg != $past(prog_reg))
    else $error("mode toggle wrong");
  c_alarm_ann:  cover property (state_reg == S_FLASH ##1 state_reg == S_ANN_CAUSE);
  c_pw_correct: cover property (state_reg == S_VERDICT && verdict_ok_reg);
  c_extreme:    cover property (state_reg == S_EXTREME ##1 state_reg == S_LIVE);
  c_log_browse: cover property (state_reg == S_LOGVAL ##1 state_reg == S_LOGWIN);

endmodule

// ---- verification/bdp_trip_unit_model.sv ----
/*
  bdp_trip_unit_model: behavioural trip unit on the far side of the menu sequencer.
  Assumes the bench raises trip and alarm requests on the shared clock; logs stay empty until an event.
*/
`timescale 1ns/10ps
module bdp_trip_unit_model
  import bdp_pkg::*;
(
  // clock and requests from the bench
  input  wire logic clk,
  input  wire logic do_trip,
  input  wire logic do_alarm,
  // pins and log records toward the panel
  output logic      alarm_relay,
  output logic      breaker_closed,
  output bdp_log_t  alarm_log,
  output bdp_log_t  trip_log
);
  // ----------------------------------------
  // event pins and latched records
  // ----------------------------------------
  initial begin
    alarm_relay    = 1'b0;
    breaker_closed = 1'b1;
    alarm_log      = '0;
    trip_log       = '0;
  end
  // a record is kept once made, as the unit's memory would keep it
  always @(posedge clk) begin
    alarm_relay    <= do_alarm;
    breaker_closed <= !do_trip;
    if (do_alarm) begin
      alarm_log <= {1'b1, 5'h01, BDP_G_CURR};
    end
    if (do_trip) begin
      trip_log <= {1'b1, 5'h02, BDP_G_CURR};
    end
  end
endmodule

// ---- verification/bdp_menu_tb.sv ----
/*
  bdp_menu_tb: self-checking bench for the menu sequencer, one task per scenario.
  Assumes a 2-cycle ms tick so the 4 s and 2 s timers fit the run; the 5 min timeout is not exercised.
*/
`timescale 1ns/10ps
module bdp_menu_tb;
  import bdp_pkg::*;
  localparam bdp_keys_t K_UP = 6'h20, K_DN = 6'h10, K_RD = 6'h08, K_EN = 6'h04, K_MX = 6'h02, K_MN = 6'h01;
  localparam bdp_keys_t K_TG = 6'h0C;
  logic      clk = 1'b0, rst_n = 1'b0, do_trip = 1'b0, do_alarm = 1'b0, relay, closed;
  bdp_keys_t keys = '0;
  logic [31:0] ekwh = 32'h0000270F;
  bdp_log_t  alog, tlog;
  bdp_disp_t d;
  int        miscompares = 0, checked = 0;
  always #5 clk = ~clk;
  bdp_trip_unit_model i_tu (.clk(clk), .do_trip(do_trip), .do_alarm(do_alarm), .alarm_relay(relay),
    .breaker_closed(closed), .alarm_log(alog), .trip_log(tlog));
  bdp_menu #(.TICK_DIV(2)) i_dut (.clk(clk), .rst_n(rst_n), .keys_raw(keys), .alarm_relay_raw(relay),
    .breaker_closed_raw(closed), .alarm_log(alog), .trip_log(tlog), .energy_kwh(ekwh),
    .energy_kqh(32'h00002710), .pf_max_leading(1'b1), .options_gn(2'h3), .password_stored(16'h0001), .disp(d));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // hold keys two cycles, then leave them low long enough for the answer to settle
  task automatic press(input bdp_keys_t k, input int n = 1);
    repeat (n) begin
      @(negedge clk) keys = k;
      repeat (2) @(negedge clk);
      keys = '0;
      repeat (8) @(negedge clk);
    end
  endtask
  task automatic wait_for(input logic [31:0] e, input int lim, input bit src);
    int i;
    for (i = 0; i < lim && (src ? d.source : d.msg) !== e; i++) @(negedge clk);
    if ((src ? d.source : d.msg) !== e) begin
      chk("wait", src ? d.source : d.msg, e);
      test_done();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_browse();
    chk("window", d.window, 0);
    repeat (8100) @(negedge clk);
    chk("window", d.window, 1);
    press(K_DN);
    chk("window", d.window, 2);
    press(K_DN, 12);
    chk("mega", d.mega, 0);
    @(negedge clk) ekwh = 32'h00002710;
    repeat (2) @(negedge clk);
    chk("mega", d.mega, 1);
    press(K_MX);
    chk("source", d.source, BDP_SRC_MAX);
    press(K_DN);
    chk("window", d.window, IDX_REACT);
    chk("source", d.source, BDP_SRC_LIVE);
    chk("mega", d.mega, 1);
    press(K_DN);
    press(K_RD);
    chk("msg", d.msg, BDP_MSG_NOLOG);
    press(K_RD);
    chk("msg", d.msg, BDP_MSG_ALOG);
    press(K_UP);
    chk("msg", d.msg, BDP_MSG_DATA);
    chk("window", d.window, IDX_REACT);
  endtask
  task automatic t_extreme();
    press(K_TG, 2);
    chk("window", d.window, 0);
    press(K_DN, 10);
    press(K_MN);
    chk("source", d.source, BDP_SRC_MIN);
    press(K_MX);
    chk("pf lead", d.pf_lead_flag, 1);
    wait_for(BDP_SRC_LIVE, 9000, 1);
    chk("window", d.window, IDX_PF);
  endtask
  task automatic t_events();
    @(negedge clk) do_alarm = 1'b1;
    wait_for(BDP_MSG_ALOG, 20, 0);
    press(K_UP);
    chk("alog", d.msg == BDP_MSG_ALOG, 0);
    press(K_DN, 6);
    press(K_RD);
    chk("cause", d.cause, 5'h01);
    chk("msg", d.msg, BDP_MSG_CAUSE);
    press(K_RD);
    chk("value", d.value_sel, V_IA);
    @(negedge clk) do_alarm = 1'b0;
    @(negedge clk) begin
      do_alarm = 1'b1;
      do_trip  = 1'b1;
    end
    wait_for(BDP_MSG_TLOG, 20, 0);
    chk("msg", d.msg, BDP_MSG_TLOG);
    chk("cause", d.cause, 5'h02);
    @(negedge clk) do_trip = 1'b0;
    repeat (10) @(negedge clk);
    chk("tlog", d.msg == BDP_MSG_TLOG, 0);
    chk("msg", d.msg, BDP_MSG_ALOG);
  endtask
  task automatic t_password();
    press(K_TG);
    press(K_DN);
    chk("window", d.window, IDX_PWD);
    press(K_EN);
    chk("msg", d.msg, BDP_MSG_PWENTRY);
    chk("cursor", d.pw_cursor, 1);
    press(K_UP);
    chk("digit", d.pw_digits[3:0], 1);
    press(K_EN);
    chk("cursor", d.pw_cursor, 2);
    press(K_DN);
    chk("digit", d.pw_digits[7:4], 9);
    press(K_UP);
    chk("digit", d.pw_digits[7:4], 0);
    press(K_EN, 3);
    chk("msg", d.msg, BDP_MSG_CORRECT);
    wait_for(BDP_MSG_PWD, 5000, 0);
    chk("window", d.window, IDX_PWD);
    chk("edit", d.edit_ok, 1);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_browse();
    t_extreme();
    t_events();
    t_password();
    test_done();
  end
endmodule
